// file: verilog/pms_pkg.sv
package pms_pkg;

	typedef enum logic [1:0] {
		PMS_OFF,
		PMS_MAN,
		PMS_SEMI,
		PMS_AUTO
	} pms_mode_t;

	typedef enum logic [2:0] {
		PMS_P_IDLE,
		PMS_P_DET,
		PMS_P_CLS,
		PMS_P_CLS2,
		PMS_P_RDY,
		PMS_P_ON,
		PMS_P_COOL
	} pms_pst_t;

	// register byte offsets
	localparam logic [7:0] PMS_A_MODE  = 8'h00;
	localparam logic [7:0] PMS_A_EN    = 8'h04;
	localparam logic [7:0] PMS_A_POWER = 8'h08;
	localparam logic [7:0] PMS_A_TECL  = 8'h0C;
	localparam logic [7:0] PMS_A_CURRENT_FOLDBACK_LIMIT_FAULT  = 8'h10;
	localparam logic [7:0] PMS_A_START = 8'h14;
	localparam logic [7:0] PMS_A_COOL  = 8'h18;
	localparam logic [7:0] PMS_A_STAT  = 8'h1C;

	localparam int PMS_MASK_BIT = 4;

	// class result codes from the classification front end
	localparam logic [2:0] PMS_CLS_4   = 3'h4;
	localparam logic [2:0] PMS_CLS_OC  = 3'h5;
	localparam logic [2:0] PMS_CLS_MIS = 3'h6;
	localparam logic [2:0] PMS_CLS_UNK = 3'h7;

	localparam logic [2:0] PMS_ICUT_LOW  = 3'h0;
	localparam logic [2:0] PMS_ICUT_HIGH = 3'h6;

	// timing
	localparam int PMS_CLK_HZ     = 10_000_000;
	localparam int PMS_TON_MS     = 400;
	localparam int PMS_TON_CYC    = PMS_TON_MS * (PMS_CLK_HZ / 1000);
	localparam int PMS_STAG_CYC   = 2000;
	localparam int PMS_TICK_CYC   = 1000;
	localparam int PMS_TON_W      = 22;
	localparam int PMS_CNT_W      = 16;
	localparam int PMS_BOOT_CAP   = 2;

	typedef struct packed {
		logic       det_done;
		logic       det_ok;
		logic       cls_done;
		logic [2:0] cls_code;
		logic       start_oc;
		logic       ocut;
		logic       foldback;
		logic       disc;
	} pms_port_in_t;

	typedef struct packed {
		logic       det_req;
		logic       cls_req;
		logic       pwr_en;
		logic [2:0] current_foldback_limit_fault;
		logic       hp;
	} pms_port_out_t;

	typedef struct packed {
		pms_mode_t [3:0]                mode;
		pms_pst_t  [3:0]                st;
		logic [3:0]                     det_en;
		logic [3:0]                     cls_en;
		logic [3:0]                     tecl;
		logic [3:0]                     flag;
		logic [3:0]                     pend;
		logic [3:0]                     det_req;
		logic [3:0]                     cls_req;
		logic                           mask;
		logic [3:0][2:0]                current_foldback_limit_fault;
		logic [3:0]                     hp;
		logic [3:0][2:0]                cls;
		logic [7:0]                     cool_len;
		logic [3:0][7:0]                cool;
		logic [3:0][PMS_TON_W-1:0]      ton;
		logic [PMS_CNT_W-1:0]           gap;
		logic [PMS_CNT_W-1:0]           tick;
		logic                           boot_s1;
		logic                           boot_s2;
		logic [1:0]                     boot_cnt;
		logic [31:0]                    prdata;
		logic                           pslverr;
	} pms_state_t;

	function automatic logic pms_cls_good(input logic [2:0] code);
		return code <= PMS_CLS_4;
	endfunction

endpackage

// file: verilog/pms_sequencer.sv
`timescale 1ns/1ns
`default_nettype none

module pms_sequencer
	import pms_pkg::*;
#(
	parameter int TON_CYC  = PMS_TON_CYC,
	parameter int STAG_CYC = PMS_STAG_CYC,
	parameter int TICK_CYC = PMS_TICK_CYC
) (
	input  wire logic                sys_clk,  // 10 MHz clock
	input  wire logic                reset,    // async, active high
	input  wire logic                boot_pin, // standalone strap pin
	input  wire logic                psel,     // apb select
	input  wire logic                penable,  // apb enable
	input  wire logic                pwrite,   // apb direction
	input  wire logic [7:0]          paddr,    // apb byte address
	input  wire logic [31:0]         pwdata,   // apb write data
	output logic [31:0]              prdata,   // apb read data
	output logic                     pready,   // apb ready
	output logic                     pslverr,  // apb error
	input  wire pms_port_in_t [3:0]  port_i,   // front end results
	output pms_port_out_t [3:0]      port_o,   // port controls
	output logic                     irq       // start fault interrupt
);

	if (TON_CYC < 1 || TON_CYC >= (1 << PMS_TON_W))
		$error("TON_CYC out of range");
	if (STAG_CYC < 1 || STAG_CYC >= (1 << PMS_CNT_W))
		$error("STAG_CYC out of range");
	if (TICK_CYC < 1 || TICK_CYC >= (1 << PMS_CNT_W))
		$error("TICK_CYC out of range");

	pms_state_t q_r;
	pms_state_t q_nxt;
	logic       wr;
	logic [3:0] button;
	logic [3:0] off_cmd;
	logic [3:0] pwr;

	assign wr      = psel & penable & pwrite;
	assign button  = (wr && paddr == PMS_A_POWER) ? pwdata[3:0] : 4'h0;
	assign off_cmd = (wr && paddr == PMS_A_POWER) ? pwdata[7:4] : 4'h0;
	assign pready  = 1'b1;
	assign prdata  = q_r.prdata;
	assign pslverr = q_r.pslverr;
	assign irq     = q_r.mask & (|q_r.flag);

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			pwr[i] = (q_r.st[i] == PMS_P_ON);
			port_o[i].det_req = q_r.det_req[i];
			port_o[i].cls_req = q_r.cls_req[i];
			port_o[i].pwr_en  = pwr[i];
			port_o[i].current_foldback_limit_fault    = q_r.current_foldback_limit_fault[i];
			port_o[i].hp      = q_r.hp[i];
		end
	end

	always_comb begin
		logic       fin;
		logic       good;
		logic       tick_hit;
		logic       fault;
		logic [3:0] det_go;
		logic [3:0] cls_go;
		logic [15:0] il;
		fin      = 1'b0;
		good     = 1'b0;
		fault    = 1'b0;
		il       = 16'h0000;
		tick_hit = (q_r.tick == '0);
		det_go   = 4'h0;
		cls_go   = 4'h0;
		q_nxt    = q_r;
		q_nxt.det_req = 4'h0;
		q_nxt.cls_req = 4'h0;
		q_nxt.tick = tick_hit ? PMS_CNT_W'(TICK_CYC - 1)
		                      : q_r.tick - 1'b1;
		if (q_r.gap != '0)
			q_nxt.gap = q_r.gap - 1'b1;

		// strap sampled two edges after release, once synchronised
		q_nxt.boot_s1 = boot_pin;
		q_nxt.boot_s2 = q_r.boot_s1;
		if (q_r.boot_cnt != 2'(PMS_BOOT_CAP + 1))
			q_nxt.boot_cnt = q_r.boot_cnt + 1'b1;
		if (q_r.boot_cnt == 2'(PMS_BOOT_CAP) && q_r.boot_s2) begin
			q_nxt.mode   = '{PMS_AUTO, PMS_AUTO, PMS_AUTO, PMS_AUTO};
			q_nxt.det_en = 4'hF;
			q_nxt.cls_en = 4'hF;
			q_nxt.tecl   = 4'hF;
			q_nxt.mask   = 1'b1;
		end

		// register writes
		if (wr) begin
			case (paddr)
				PMS_A_MODE: for (int i = 0; i < 4; i++)
					q_nxt.mode[i] = pms_mode_t'(pwdata[2*i +: 2]);
				PMS_A_EN: begin
					det_go = pwdata[3:0] & ~q_r.det_en;
					cls_go = pwdata[7:4] & ~q_r.cls_en;
					q_nxt.det_en = pwdata[3:0];
					q_nxt.cls_en = pwdata[7:4];
				end
				PMS_A_TECL: q_nxt.tecl = pwdata[3:0];
				PMS_A_CURRENT_FOLDBACK_LIMIT_FAULT: begin
					for (int i = 0; i < 4; i++) begin
						q_nxt.current_foldback_limit_fault[i] = pwdata[4*i +: 3];
						q_nxt.hp[i]   = pwdata[4*i + 3];
					end
				end
				PMS_A_START: begin
					q_nxt.flag = q_r.flag & ~pwdata[3:0];
					q_nxt.mask = pwdata[PMS_MASK_BIT];
				end
				PMS_A_COOL: q_nxt.cool_len = pwdata[7:0];
				default: ;
			endcase
		end

		// read data captured in the setup cycle, so access needs no wait
		if (psel && !penable) begin
			q_nxt.pslverr = 1'b0;
			for (int i = 0; i < 4; i++)
				il[4*i +: 4] = {q_r.hp[i], q_r.current_foldback_limit_fault[i]};
			case (paddr)
				PMS_A_MODE:  q_nxt.prdata = {24'h00_0000, q_r.mode};
				PMS_A_EN:    q_nxt.prdata = {24'h00_0000, q_r.cls_en,
				                             q_r.det_en};
				PMS_A_POWER: q_nxt.prdata = {24'h00_0000, q_r.pend, pwr};
				PMS_A_TECL:  q_nxt.prdata = {28'h000_0000, q_r.tecl};
				PMS_A_CURRENT_FOLDBACK_LIMIT_FAULT:  q_nxt.prdata = {16'h0000, il};
				PMS_A_START: q_nxt.prdata = {27'h000_0000, q_r.mask,
				                             q_r.flag};
				PMS_A_COOL:  q_nxt.prdata = {24'h00_0000, q_r.cool_len};
				PMS_A_STAT:  q_nxt.prdata = {20'h0_0000, q_r.st};
				default: begin
					q_nxt.prdata  = 32'h0000_0000;
					q_nxt.pslverr = 1'b1;
				end
			endcase
		end

		for (int i = 0; i < 4; i++) begin
			fin   = 1'b0;
			good  = 1'b0;
			fault = port_i[i].start_oc | port_i[i].ocut |
			        port_i[i].foldback;
			if (q_r.ton[i] != '0)
				q_nxt.ton[i] = q_r.ton[i] - 1'b1;

			case (q_r.st[i])
				PMS_P_IDLE: begin
					if (q_r.mode[i] == PMS_MAN) begin
						if (det_go[i]) begin
							q_nxt.st[i]      = PMS_P_DET;
							q_nxt.det_req[i] = 1'b1;
						end else if (cls_go[i]) begin
							q_nxt.st[i]      = PMS_P_CLS;
							q_nxt.cls_req[i] = 1'b1;
						end
					end else if (q_r.mode[i] != PMS_OFF && q_r.det_en[i])
						begin
						q_nxt.st[i]      = PMS_P_DET;
						q_nxt.det_req[i] = 1'b1;
						q_nxt.cls[i]     = 3'h0;
					end
				end
				PMS_P_DET: begin
					if (port_i[i].det_done) begin
						if (port_i[i].det_ok)
							q_nxt.ton[i] = PMS_TON_W'(TON_CYC);
						if (q_r.mode[i] == PMS_MAN)
							q_nxt.st[i] = PMS_P_IDLE;
						else if (port_i[i].det_ok && q_r.cls_en[i]) begin
							q_nxt.st[i]      = PMS_P_CLS;
							q_nxt.cls_req[i] = 1'b1;
						end else begin
							fin  = 1'b1;
							good = port_i[i].det_ok;
						end
					end
				end
				PMS_P_CLS, PMS_P_CLS2: begin
					if (port_i[i].cls_done) begin
						q_nxt.cls[i] = port_i[i].cls_code;
						if (q_r.st[i] == PMS_P_CLS &&
						    port_i[i].cls_code == PMS_CLS_4 &&
						    q_r.tecl[i]) begin
							q_nxt.st[i]      = PMS_P_CLS2;
							q_nxt.cls_req[i] = 1'b1;
						end else if (q_r.mode[i] == PMS_MAN)
							q_nxt.st[i] = PMS_P_IDLE;
						else begin
							fin  = 1'b1;
							good = pms_cls_good(port_i[i].cls_code);
						end
					end
				end
				PMS_P_RDY: begin
					if (q_r.ton[i] == '0) begin
						q_nxt.st[i]      = PMS_P_DET;
						q_nxt.det_req[i] = 1'b1;
					end else if (q_r.gap == '0 && q_nxt.gap == '0) begin
						q_nxt.st[i]   = PMS_P_ON;
						q_nxt.pend[i] = 1'b0;
						q_nxt.gap     = PMS_CNT_W'(STAG_CYC);
						if (q_r.mode[i] == PMS_AUTO) begin
							q_nxt.current_foldback_limit_fault[i] = (q_r.cls[i] == PMS_CLS_4)
							              ? PMS_ICUT_HIGH : PMS_ICUT_LOW;
							q_nxt.hp[i]   = (q_r.cls[i] == PMS_CLS_4);
						end
					end
				end
				PMS_P_COOL: begin
					if (tick_hit) begin
						if (q_r.cool[i] == 8'h00)
							q_nxt.st[i] = PMS_P_IDLE;
						else
							q_nxt.cool[i] = q_r.cool[i] - 1'b1;
					end
				end
				default: ;
			endcase

			// end of a semi or auto cycle
			if (fin) begin
				if (!good) begin
					if (q_r.mode[i] == PMS_AUTO || q_r.pend[i])
						q_nxt.flag[i] = 1'b1;
					q_nxt.pend[i] = 1'b0;
					q_nxt.st[i]   = PMS_P_IDLE;
				end else if (q_r.mode[i] == PMS_AUTO || q_r.pend[i])
					q_nxt.st[i] = PMS_P_RDY;
				else
					q_nxt.st[i] = PMS_P_IDLE;
			end

			// push-button request
			if (button[i]) begin
				case (q_r.mode[i])
					PMS_MAN: begin
						if (!fault)
							q_nxt.st[i] = PMS_P_ON;
					end
					PMS_SEMI: begin
						if (q_r.st[i] != PMS_P_COOL &&
						    q_r.st[i] != PMS_P_ON &&
						    q_r.det_en[i])
							q_nxt.pend[i] = 1'b1;
					end
					default: ;
				endcase
			end

			// shutdown causes for a powered port
			if (q_r.st[i] == PMS_P_ON) begin
				if (fault) begin
					if (q_r.mode[i] == PMS_MAN)
						q_nxt.st[i] = PMS_P_IDLE;
					else begin
						q_nxt.st[i]   = PMS_P_COOL;
						q_nxt.cool[i] = q_r.cool_len;
					end
				end else if (port_i[i].disc || off_cmd[i])
					q_nxt.st[i] = PMS_P_IDLE;
			end
			if (port_i[i].start_oc && q_r.mode[i] != PMS_OFF)
				q_nxt.flag[i] = 1'b1;

			if (q_r.mode[i] == PMS_OFF) begin
				q_nxt.st[i]     = PMS_P_IDLE;
				q_nxt.pend[i]   = 1'b0;
				q_nxt.det_en[i] = 1'b0;
				q_nxt.cls_en[i] = 1'b0;
				q_nxt.flag[i]   = 1'b0;
				q_nxt.det_req[i] = 1'b0;
				q_nxt.cls_req[i] = 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			q_r        <= '0;
			q_r.mode   <= '{PMS_AUTO, PMS_AUTO, PMS_AUTO, PMS_AUTO};
			q_r.det_en <= 4'hF;
			q_r.cls_en <= 4'hF;
			q_r.mask   <= 1'b1;
		end else begin
			q_r <= q_nxt;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	localparam int P0 = 0, P1 = 1, P2 = 2, P3 = 3; // ports per scenario

	property p_off_dark;
		q_r.mode[P1] == PMS_OFF |=> !pwr[P1];
	endproperty
	a_off_dark: assert property (p_off_dark)
		else $error("off port powered");

	property p_man_no_cool;
		q_r.mode[P3] == PMS_MAN && pwr[P3] && port_i[P3].ocut
		|=> q_r.st[P3] == PMS_P_IDLE;
	endproperty
	a_man_no_cool: assert property (p_man_no_cool)
		else $error("manual fault entered cool-down");

	property p_cool_ignore;
		q_r.st[P0] == PMS_P_COOL && button[P0] |=> !pwr[P0] && !q_r.pend[P0];
	endproperty
	a_cool_ignore: assert property (p_cool_ignore)
		else $error("power request taken in cool-down");

	property p_semi_refuse;
		q_r.mode[P2] == PMS_SEMI && !q_r.det_en[P2] && !q_r.pend[P2]
		&& !(wr && paddr == PMS_A_EN) |=> !q_r.pend[P2];
	endproperty
	a_semi_refuse: assert property (p_semi_refuse)
		else $error("semi request accepted without detect");

	property p_auto_limit;
		$rose(pwr[P0]) && q_r.mode[P0] == PMS_AUTO |->
		q_r.current_foldback_limit_fault[P0] == ((q_r.cls[P0] == PMS_CLS_4) ? PMS_ICUT_HIGH
		                 : PMS_ICUT_LOW) && q_r.hp[P0] == (q_r.cls[P0] ==
		                 PMS_CLS_4);
	endproperty
	a_auto_limit: assert property (p_auto_limit)
		else $error("auto limit code wrong");

	property p_bad_detect_flag;
		q_r.mode[P2] == PMS_SEMI && q_r.pend[P2] &&
		q_r.st[P2] == PMS_P_DET && port_i[P2].det_done &&
		!port_i[P2].det_ok |=> q_r.flag[P2] && !pwr[P2] ##1 !pwr[P2];
	endproperty
	a_bad_detect_flag: assert property (p_bad_detect_flag)
		else $error("invalid detect did not flag");

	property p_irq;
		$rose(q_r.flag[P2]) && q_r.mask |-> irq;
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt missing");

	property p_man_button;
		q_r.mode[P3] == PMS_MAN && button[P3] && !port_i[P3].start_oc &&
		!port_i[P3].ocut && !port_i[P3].foldback |=> pwr[P3];
	endproperty
	a_man_button: assert property (p_man_button)
		else $error("manual button did not power");

	property p_semi_needs_req;
		$rose(pwr[P2]) && q_r.mode[P2] == PMS_SEMI |->
		$past(q_r.pend[P2]) || $past(button[P2]);
	endproperty
	a_semi_needs_req: assert property (p_semi_needs_req)
		else $error("semi powered without request");

	property p_stagger;
		$rose(pwr[P0]) && q_r.mode[P0] != PMS_MAN &&
		q_r.mode[P1] != PMS_MAN |-> !$rose(pwr[P1]);
	endproperty
	a_stagger: assert property (p_stagger)
		else $error("ports powered together");

	c_auto_on:  cover property ($rose(pwr[P0]) && q_r.mode[P0] == PMS_AUTO);
	c_semi_on:  cover property ($rose(pwr[P2]) && q_r.mode[P2] == PMS_SEMI);
	c_cool_end: cover property (q_r.st[P0] == PMS_P_COOL ##1
	                            q_r.st[P0] == PMS_P_IDLE);
	c_flag:     cover property ($rose(q_r.flag[P0]));

endmodule

`default_nettype wire

// file: dv/pms_pd_model.sv
`timescale 1ns/1ns
`default_nettype none
module pms_pd_model
	import pms_pkg::*;
#(
	parameter int DLY = 2
) (
	input  wire logic                sys_clk, // clock
	input  wire logic                reset,   // async reset
	input  wire pms_port_out_t [3:0] port_o,  // requests from ports
	input  wire logic [3:0]          good,    // detect outcome
	input  wire logic [3:0][2:0]     cls,     // class outcome
	input  wire logic [3:0]          ocut,    // overload pulses
	input  wire logic [3:0]          disc,    // unplug pulses
	output pms_port_in_t [3:0]       port_i   // results to ports
);
	logic [3:0][3:0] dcnt;
	logic [3:0][3:0] ccnt;

	// each port answers after its own delay, so ports requested together never align
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			dcnt <= '0;
			ccnt <= '0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				dcnt[i] <= port_o[i].det_req ? 4'(DLY + i) :
					dcnt[i] - 4'(dcnt[i] != 4'h0);
				ccnt[i] <= port_o[i].cls_req ? 4'(DLY + i) :
					ccnt[i] - 4'(ccnt[i] != 4'h0);
			end
		end
	end

	// off-pulse results inverted so a stale sample never passes as valid
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			port_i[i].det_done = dcnt[i] == 4'h1;
			port_i[i].det_ok = (dcnt[i] == 4'h1) ? good[i] : ~good[i];
			port_i[i].cls_done = ccnt[i] == 4'h1;
			port_i[i].cls_code = (ccnt[i] == 4'h1) ? cls[i] : ~cls[i];
			port_i[i].start_oc = 1'b0;
			port_i[i].ocut = ocut[i];
			port_i[i].foldback = 1'b0;
			port_i[i].disc = disc[i];
		end
	end
endmodule
`default_nettype wire

// file: dv/pms_sequencer_tb.sv
`timescale 1ns/1ns
`default_nettype none
module pms_sequencer_tb
	import pms_pkg::*;
;
	logic             sys_clk = 1'b0;
	logic             reset = 1'b1;
	logic             boot = 1'b0;
	logic             psel = 1'b0;
	logic             penable = 1'b0;
	logic             pwrite = 1'b0;
	logic [7:0]       paddr = 8'h00;
	logic [31:0]      pwdata = 32'h0000_0000;
	logic [31:0]      prdata;
	logic [31:0]      rd;
	logic             pready;
	logic             pslverr;
	logic             err;
	logic             irq;
	pms_port_in_t [3:0]  port_i;
	pms_port_out_t [3:0] port_o;
	logic [3:0]       good = 4'hF;
	logic [3:0]       ocut = 4'h0;
	logic [3:0]       disc = 4'h0;
	logic [3:0]       pw;
	logic [3:0]       pw_q = 4'h0;
	logic [3:0][2:0]  cls = {3'h3, 3'h6, 3'h4, 3'h2};
	int               error_cnt = 0;
	int               checks_done = 0;
	int               cyc = 0;
	int               n;
	int               dq[4] = '{default: 0};
	int               cq[4] = '{default: 0};

	always #50 sys_clk = ~sys_clk;

	pms_sequencer #(.TON_CYC(200), .STAG_CYC(5), .TICK_CYC(3)) u_dut (
		.sys_clk(sys_clk), .reset(reset), .boot_pin(boot), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .port_i(port_i), .port_o(port_o), .irq(irq));

	pms_pd_model u_pd (
		.sys_clk(sys_clk), .reset(reset), .port_o(port_o), .good(good),
		.cls(cls), .ocut(ocut), .disc(disc), .port_i(port_i));

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			pw[i] = port_o[i].pwr_en;
		end
	end

	task automatic chk(input string nm, input logic [31:0] got, exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic conclude;
		$display("mismatches %0d checks %0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// sampled at the falling edge, where outputs have settled
	always @(negedge sys_clk) begin
		cyc++;
		pw_q <= pw;
		if (!reset && (pw & ~pw_q) != 4'h0)
			chk("stagger", 32'($countones(pw & ~pw_q) > 1), 0);
		for (int i = 0; i < 4; i++) begin
			dq[i] += int'(port_o[i].det_req);
			cq[i] += int'(port_o[i].cls_req);
		end
		if (cyc == 20000) begin
			error_cnt++;
			conclude();
		end
	end

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1) @(posedge sys_clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdc(input string nm, input logic [7:0] a,
		input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(nm, rd, e);
	endtask

	task automatic idle(input int k);
		repeat (k) @(negedge sys_clk);
	endtask

	task automatic wait_pw(input int p, input logic v, input int lim);
		int k;
		k = 0;
		while (pw[p] !== v && k < lim) begin
			@(negedge sys_clk);
			k++;
		end
		chk("pwr_en", 32'(pw[p]), 32'(v));
	endtask

	// one-cycle fault or unplug pulse on a port
	task automatic hit(input int p, input logic unplug);
		@(posedge sys_clk);
		if (unplug)
			disc[p] <= 1'b1;
		else
			ocut[p] <= 1'b1;
		@(posedge sys_clk);
		disc <= 4'h0;
		ocut <= 4'h0;
	endtask

	initial begin
		repeat (20) @(posedge sys_clk);
		reset <= 1'b0;
		rdc("mode", PMS_A_MODE, 32'h0000_00FF);
		rdc("enable", PMS_A_EN, 32'h0000_00FF);
		rdc("two_event", PMS_A_TECL, 32'h0000_0000);
		rdc("start", PMS_A_START, 32'h0000_0010);
		rdc("cooldown", PMS_A_COOL, 32'h0000_0000);
		apb(1'b0, 8'h20, 32'h0000_0000);
		chk("unmapped_rd", rd, 32'h0000_0000);
		chk("unmapped_err", 32'(err), 32'h0000_0001);
		n = 0;
		while (pw !== 4'b1011 && n < 600) begin
			idle(1);
			n++;
		end
		chk("auto_power", 32'(pw), 32'h0000_000B);
		chk("det_count", 32'(dq[1]), 32'h0000_0001);
		chk("class_count", 32'(cq[1]), 32'h0000_0001);
		rdc("limit", PMS_A_CURRENT_FOLDBACK_LIMIT_FAULT, 32'h0000_00E0);
		chk("limit_pin", 32'({port_o[1].hp, port_o[1].current_foldback_limit_fault}), 32'h0000_000E);
		rdc("start", PMS_A_START, 32'h0000_0014);
		chk("irq_on", 32'(irq), 32'h0000_0001);
		wr(PMS_A_START, 32'h0000_0004);
		idle(2);
		chk("irq_masked", 32'(irq), 32'h0000_0000);
		wr(PMS_A_MODE, 32'h0000_00EF);
		wr(PMS_A_START, 32'h0000_0004);
		rdc("start", PMS_A_START, 32'h0000_0000);
		// fault, then button during cool-down, then automatic recovery
		wr(PMS_A_COOL, 32'h0000_0014);
		wr(PMS_A_EN, 32'h0000_0001);
		hit(0, 1'b0);
		idle(1);
		chk("fault_off", 32'(pw[0]), 32'h0000_0000);
		apb(1'b0, PMS_A_STAT, 32'h0000_0000);
		chk("other_on", 32'(rd[5:3]), 32'h0000_0005);
		chk("cool_state", 32'(rd[2:0]), 32'h0000_0006);
		wr(PMS_A_POWER, 32'h0000_0001);
		idle(30);
		chk("cool_block", 32'(pw[0]), 32'h0000_0000);
		wait_pw(0, 1'b1, 400);
		hit(3, 1'b1);
		idle(40);
		chk("unplug_off", 32'(pw[3]), 32'h0000_0000);
		apb(1'b0, PMS_A_STAT, 32'h0000_0000);
		chk("recovered_on", 32'(rd[2:0]), 32'h0000_0005);
		chk("unplug_idle", 32'(rd[11:9]), 32'h0000_0000);
		wr(PMS_A_MODE, 32'h0000_006F);
		wr(PMS_A_CURRENT_FOLDBACK_LIMIT_FAULT, 32'h0000_50E0);
		wr(PMS_A_POWER, 32'h0000_0008);
		wait_pw(3, 1'b1, 3);
		hit(3, 1'b0);
		idle(1);
		chk("man_fault", 32'(pw[3]), 32'h0000_0000);
		wr(PMS_A_POWER, 32'h0000_0008);
		wait_pw(3, 1'b1, 3);
		rdc("limit", PMS_A_CURRENT_FOLDBACK_LIMIT_FAULT, 32'h0000_50E0);
		wr(PMS_A_POWER, 32'h0000_0080);
		n = dq[3];
		wr(PMS_A_EN, 32'h0000_0009);
		idle(40);
		chk("man_one_det", 32'(dq[3] - n), 32'h0000_0001);
		@(posedge sys_clk);
		cls[2] <= 3'h1;
		wr(PMS_A_POWER, 32'h0000_0004);
		idle(30);
		chk("semi_refuse", 32'(pw[2]), 32'h0000_0000);
		wr(PMS_A_EN, 32'h0000_0045);
		n = dq[2];
		idle(80);
		chk("semi_repeat", 32'(dq[2] - n >= 2), 32'h0000_0001);
		wr(PMS_A_POWER, 32'h0000_0004);
		wait_pw(2, 1'b1, 300);
		rdc("limit", PMS_A_CURRENT_FOLDBACK_LIMIT_FAULT, 32'h0000_50E0);
		wr(PMS_A_POWER, 32'h0000_0040);
		idle(2);
		chk("cmd_off", 32'(pw[2]), 32'h0000_0000);
		@(posedge sys_clk);
		good[2] <= 1'b0;
		wr(PMS_A_POWER, 32'h0000_0004);
		idle(80);
		chk("bad_detect", 32'(pw[2]), 32'h0000_0000);
		rdc("start", PMS_A_START, 32'h0000_0004);
		wr(PMS_A_MODE, 32'h0000_0063);
		n = dq[1];
		idle(40);
		chk("off_power", 32'(pw[1]), 32'h0000_0000);
		chk("off_quiet", 32'(dq[1] - n), 32'h0000_0000);
		rdc("start", PMS_A_START, 32'h0000_0004);
		// second reset with the strap high
		@(posedge sys_clk);
		boot <= 1'b1;
		reset <= 1'b1;
		repeat (20) @(posedge sys_clk);
		reset <= 1'b0;
		idle(6);
		rdc("boot_tecl", PMS_A_TECL, 32'h0000_000F);
		rdc("boot_mode", PMS_A_MODE, 32'h0000_00FF);
		conclude();
	end
endmodule
`default_nettype wire
